// ==== logic/burst_read_map.svh ====
// Purpose: offsets, field codes, reset values and counts for the burst read port
// Assumes: included by its bare name from the package file only; the design modules use its macros without including it
// Notes: definitions only
`ifndef BURST_READ_MAP_SVH
`define BURST_READ_MAP_SVH

`define ADDR_W 20
`define UNIT_W 21
`define PIN_W 26
`define LEN_SEL_2 2'h0
`define LEN_SEL_4 2'h1
`define LEN_SEL_8 2'h2
`define MASK_2 3'h1
`define MASK_4 3'h3
`define MASK_8 3'h7
`define LAT_BASE 5'h02
`define LAT_MAX 5'h10
`define SECURED_LIMIT_BYTES 256
`define SECURED_LIMIT_WORDS 20'h00040
`define CFG_BURST_RST 1'b0
`define CFG_LEN_RST 2'h1
`define CFG_LAT_RST 4'h1
`define EDGE_SELECT_RST 1'b1
`define REGION_MAIN 2'h0
`define REGION_SECURED 2'h1
`define REGION_CONFIG 2'h2

`endif

// ==== logic/burst_read_pkg.sv ====
// Purpose: shared types of the burst read port
// Assumes: burst_read_map.svh holds the numbers
// Notes: none
`include "burst_read_map.svh"
package burst_read_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_LATENCY, ST_STREAM} burst_state_t;
    typedef logic [`UNIT_W-1:0] unit_addr_t;
    typedef logic [`ADDR_W-1:0] word_addr_t;
endpackage

// ==== logic/burst_seq_if.sv ====
// Purpose: carries wrap sequencing signals between controller and sequencer
// Assumes: one clock domain
// Notes: none
`timescale 1ns/100ps
interface burst_seq_if;
    logic start;
    logic advance;
    logic [20:0] start_unit;
    logic [2:0] mask;
    logic [20:0] unit_addr;
    logic last;
    modport seq(input start, input advance, input start_unit, input mask,
                output unit_addr, output last);
    modport ctrl(output start, output advance, output start_unit, output mask,
                 input unit_addr, input last);
endinterface

// ==== logic/burst_wrap_seq.sv ====
// Purpose: holds burst start address and wrapping offset
// Assumes: start and advance are one-cycle pulses
// Notes: wrap happens inside the aligned block given by mask
`timescale 1ns/100ps
module burst_wrap_seq
    import burst_read_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    burst_seq_if.seq sq
);
    unit_addr_t base_reg;
    logic [2:0] offset_reg;
    logic [2:0] offset_next;
    logic [2:0] mask_reg;

    function automatic logic [2:0] wrap_index(input logic [2:0] lo, input logic [2:0] off,
                                              input logic [2:0] mask);
        logic [2:0] sum;
        sum = lo + off;
        wrap_index = (sum & mask) | (lo & ~mask);
    endfunction

    assign offset_next = (offset_reg + 3'h1) & mask_reg;
    assign sq.unit_addr = {base_reg[20:3], wrap_index(base_reg[2:0], offset_reg, mask_reg)};
    assign sq.last = (offset_reg == mask_reg);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            base_reg <= '0;
            offset_reg <= 3'h0;
            mask_reg <= `MASK_4;
        end else if (sq.start) begin
            base_reg <= sq.start_unit;
            offset_reg <= 3'h0;
            mask_reg <= sq.mask;
        end else if (sq.advance) begin
            offset_reg <= offset_next;
        end
    end
endmodule

// ==== logic/flash_linear_burst_read_port.sv ====
// Purpose: read side of a parallel flash: asynchronous reads and wrapping bursts
// Assumes: array answers array_data_in one clk_in after array_addr_out
// Notes:
`timescale 1ns/100ps
module flash_linear_burst_read_port
    import burst_read_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flash_clk_in,
    input wire logic chip_select_n_in,
    input wire logic output_gate_n_in,
    input wire logic address_latch_strobe_n_in,
    input wire logic word_mode_n_in,
    input wire logic [19:0] addr_in,
    input wire logic addr_lsb_in,
    input wire logic [1:0] region_sel_in,
    input wire logic [31:0] array_data_in,
    input wire logic config_write_in,
    input wire logic config_burst_in,
    input wire logic [1:0] config_len_in,
    input wire logic [3:0] config_latency_in,
    output logic [31:0] data_out,
    output logic data_oe_out,
    output logic end_of_burst_n_out,
    output logic end_of_burst_oe_out,
    output logic [19:0] array_addr_out,
    output logic burst_mode_out,
    output logic burst_active_out,
    output logic data_invalid_out,
    output logic edge_select_bit_out
);
    // pin synchronisers
    logic [`PIN_W-1:0] pins_raw;
    logic [`PIN_W-1:0] s1_reg;
    logic [`PIN_W-1:0] s2_reg;
    logic [`PIN_W-1:0] s3_reg;
    logic [`PIN_W-1:0] filt_reg;
    logic [`PIN_W-1:0] filt_next;
    logic fclk_prev_reg;
    logic strobe_prev_reg;

    // configuration
    logic cfg_burst_reg;
    logic [1:0] cfg_len_reg;
    logic [3:0] cfg_lat_reg;
    logic edge_select_bit_reg;

    // burst control
    burst_state_t state_reg;
    burst_state_t state_next;
    logic [4:0] lat_cnt_reg;
    logic [4:0] lat_cnt_next;
    logic armed_reg;
    logic armed_next;
    logic [31:0] data_reg;
    logic [31:0] data_next;
    logic data_oe_reg;
    logic data_oe_next;
    logic eob_n_reg;
    logic eob_n_next;
    logic eob_oe_reg;
    logic eob_oe_next;
    word_addr_t array_addr_reg;
    word_addr_t array_addr_next;
    logic invalid_reg;
    logic invalid_next;
    logic burst_active_reg;

    burst_seq_if sq();

    burst_wrap_seq u_seq (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sq(sq)
    );

    function automatic word_addr_t unit_to_word(input unit_addr_t u, input logic word_mode);
        unit_to_word = word_mode ? u[20:1] : u[19:0];
    endfunction

    function automatic logic [31:0] half_select(input logic [31:0] w, input logic hi,
                                                input logic word_mode);
        half_select = word_mode ? {16'h0000, (hi ? w[31:16] : w[15:0])} : w;
    endfunction

    function automatic logic past_secured(input word_addr_t a, input logic [1:0] region);
        past_secured = (region == `REGION_SECURED) && (a >= `SECURED_LIMIT_WORDS);
    endfunction

    assign pins_raw = {flash_clk_in, chip_select_n_in, output_gate_n_in,
                       address_latch_strobe_n_in, word_mode_n_in, addr_lsb_in, addr_in};
    // a bit moves once the second and third stages agree
    assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));

    wire fclk_f = filt_reg[25];
    wire cs_n_f = filt_reg[24];
    wire oe_n_f = filt_reg[23];
    wire strobe_n_f = filt_reg[22];
    wire word_mode = ~filt_reg[21];
    wire unit_addr_t pin_unit = word_mode ? {filt_reg[19:0], filt_reg[20]} : {1'b0, filt_reg[19:0]};

    wire fclk_rise = fclk_f & ~fclk_prev_reg;
    wire strobe_fall = ~strobe_n_f & strobe_prev_reg;
    wire strobe_rise = strobe_n_f & ~strobe_prev_reg;
    wire selected = ~cs_n_f;
    wire gate_open = ~oe_n_f;
    wire config_read = (region_sel_in == `REGION_CONFIG);
    wire burst_path = cfg_burst_reg & ~config_read;
    wire start_ev = burst_path & selected & armed_reg &
                    ((fclk_rise & ~strobe_n_f) | strobe_rise);
    wire in_burst = (state_reg != ST_IDLE);
    wire present_ev = fclk_rise & ((state_reg == ST_STREAM) |
                      ((state_reg == ST_LATENCY) & (lat_cnt_reg == 5'h01)));
    wire [4:0] lat_sum = {1'b0, cfg_lat_reg} + `LAT_BASE;
    wire [4:0] lat_load = (lat_sum > `LAT_MAX) ? `LAT_MAX : lat_sum;
    wire [2:0] len_mask = (cfg_len_reg == `LEN_SEL_2) ? `MASK_2 :
                          (cfg_len_reg == `LEN_SEL_4) ? `MASK_4 : `MASK_8;
    wire word_addr_t seq_word = unit_to_word(sq.unit_addr, word_mode);
    wire [31:0] shaped_word = half_select(array_data_in, sq.unit_addr[0], word_mode);
    wire [31:0] async_word = half_select(array_data_in, pin_unit[0], word_mode);

    assign sq.start = start_ev;
    assign sq.advance = present_ev & ~start_ev;
    assign sq.start_unit = pin_unit;
    assign sq.mask = len_mask;

    always_comb begin
        state_next = state_reg;
        lat_cnt_next = lat_cnt_reg;
        armed_next = armed_reg;
        data_next = data_reg;
        data_oe_next = 1'b0;
        eob_n_next = eob_n_reg;
        eob_oe_next = 1'b0;
        array_addr_next = array_addr_reg;
        invalid_next = invalid_reg;
        if (strobe_fall) begin
            armed_next = 1'b1;
        end
        if (!burst_path) begin
            // asynchronous reads, with burst mode off or the config region selected
            state_next = ST_IDLE;
            array_addr_next = unit_to_word(pin_unit, word_mode);
            data_next = async_word;
            invalid_next = past_secured(array_addr_reg, region_sel_in);
            data_oe_next = selected & gate_open;
            eob_n_next = 1'b1;
        end else begin
            array_addr_next = seq_word;
            if (!selected) begin
                state_next = ST_IDLE;
                armed_next = 1'b0;
                eob_n_next = 1'b1;
            end else if (start_ev) begin
                state_next = ST_LATENCY;
                lat_cnt_next = lat_load;
                armed_next = 1'b0;
                eob_n_next = 1'b1;
            end else if (strobe_fall && in_burst) begin
                state_next = ST_IDLE;
                eob_n_next = 1'b1;
            end else if (present_ev) begin
                state_next = ST_STREAM;
                data_next = shaped_word;
                invalid_next = past_secured(array_addr_reg, region_sel_in);
                eob_n_next = ~sq.last;
            end else if (fclk_rise && state_reg == ST_LATENCY) begin
                lat_cnt_next = lat_cnt_reg - 5'h01;
            end
            data_oe_next = selected & gate_open & (state_next == ST_STREAM);
            eob_oe_next = selected & gate_open;
        end
    end

    always_ff @(posedge clk_in) begin
        s1_reg <= pins_raw;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        filt_reg <= filt_next;
        fclk_prev_reg <= filt_reg[25];
        strobe_prev_reg <= filt_reg[22];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_burst_reg <= `CFG_BURST_RST;
            cfg_len_reg <= `CFG_LEN_RST;
            cfg_lat_reg <= `CFG_LAT_RST;
            edge_select_bit_reg <= `EDGE_SELECT_RST;
        end else if (config_write_in) begin
            cfg_burst_reg <= config_burst_in;
            cfg_len_reg <= config_len_in;
            cfg_lat_reg <= config_latency_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            lat_cnt_reg <= 5'h00;
            armed_reg <= 1'b0;
            data_reg <= 32'h00000000;
            data_oe_reg <= 1'b0;
            eob_n_reg <= 1'b1;
            eob_oe_reg <= 1'b0;
            array_addr_reg <= '0;
            invalid_reg <= 1'b0;
            burst_active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lat_cnt_reg <= lat_cnt_next;
            armed_reg <= armed_next;
            data_reg <= data_next;
            data_oe_reg <= data_oe_next;
            eob_n_reg <= eob_n_next;
            eob_oe_reg <= eob_oe_next;
            array_addr_reg <= array_addr_next;
            invalid_reg <= invalid_next;
            burst_active_reg <= (state_next != ST_IDLE);
        end
    end

    assign data_out = data_reg;
    assign data_oe_out = data_oe_reg;
    assign end_of_burst_n_out = eob_n_reg;
    assign end_of_burst_oe_out = eob_oe_reg;
    assign array_addr_out = array_addr_reg;
    assign burst_mode_out = cfg_burst_reg;
    assign burst_active_out = burst_active_reg;
    assign data_invalid_out = invalid_reg;
    assign edge_select_bit_out = edge_select_bit_reg;
endmodule

// ==== testbench/burst_port_chk.sv ====
// Purpose: port checks of the burst read port
// Assumes: bound to the top module
// Notes: pins reach the logic about five clocks late
`timescale 1ns/100ps
module burst_port_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic chip_select_n_in,
    input wire logic output_gate_n_in,
    input wire logic config_write_in,
    input wire logic config_burst_in,
    input wire logic [31:0] data_out,
    input wire logic data_oe_out,
    input wire logic end_of_burst_n_out,
    input wire logic end_of_burst_oe_out,
    input wire logic burst_mode_out,
    input wire logic burst_active_out,
    input wire logic edge_select_bit_out
);
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    chk_reset_floats_pins: assert property (disable iff (1'b0) rst_in |=>
        !data_oe_out && !end_of_burst_oe_out && !burst_mode_out) else $error("reset");
    chk_edge_bit_one: assert property (edge_select_bit_out) else $error("edge bit");
    chk_cfg_load: assert property (config_write_in |=>
        burst_mode_out == $past(config_burst_in)) else $error("config");
    chk_gate_floats: assert property (output_gate_n_in [*7] |->
        !data_oe_out && !end_of_burst_oe_out) else $error("gate");
    chk_cs_abandons: assert property (chip_select_n_in [*7] |->
        !data_oe_out && !burst_active_out) else $error("select");
    chk_eob_aligned: assert property ($changed(end_of_burst_n_out) && end_of_burst_oe_out
        |-> $changed(data_out)) else $error("eob align");
    chk_eob_in_burst: assert property ($fell(end_of_burst_n_out) |->
        burst_active_out && end_of_burst_oe_out) else $error("eob burst");
    chk_eob_mode_only: assert property (end_of_burst_oe_out |-> burst_mode_out)
        else $error("eob mode");
endmodule

// ==== testbench/flash_array_model.sv ====
// Purpose: array behind the port
// Assumes: answers one clock after the address
// Notes: data pattern carries the word address
`timescale 1ns/100ps
module flash_array_model (
    input wire logic clk_in,
    input wire logic [19:0] array_addr_in,
    output logic [31:0] array_data_out
);
    always_ff @(posedge clk_in) begin
        array_data_out <= {12'h5A5, array_addr_in};
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the burst read port
// Assumes: host pins change at falling clk_in edges
// Notes: flash clock period is sixteen clk_in cycles
`timescale 1ns/100ps
module testbench;
    logic clk_in = 1'b0, rst_in = 1'b1, fclk = 1'b0, cs_n = 1'b1, og_n = 1'b1, st_n = 1'b1;
    logic cw = 1'b0, cb = 1'b0, wm_n = 1'b1;
    logic [1:0] rs = 2'h0, cl = 2'h0;
    logic [3:0] clat = 4'h0;
    logic [19:0] a = 20'h00000, aa;
    logic [15:0] lfsr_reg = 16'h003A;
    logic [31:0] ad, dq;
    logic doe, eob, eoe, bm, ba, inv, es;
    int bad_count = 0;
    int n_checks = 0;
    flash_linear_burst_read_port i_dut (.clk_in(clk_in), .rst_in(rst_in), .flash_clk_in(fclk),
        .chip_select_n_in(cs_n), .output_gate_n_in(og_n), .address_latch_strobe_n_in(st_n),
        .word_mode_n_in(wm_n), .addr_in(a), .addr_lsb_in(1'b0), .region_sel_in(rs),
        .array_data_in(ad), .config_write_in(cw), .config_burst_in(cb), .config_len_in(cl),
        .config_latency_in(clat), .data_out(dq), .data_oe_out(doe), .end_of_burst_n_out(eob),
        .end_of_burst_oe_out(eoe), .array_addr_out(aa), .burst_mode_out(bm),
        .burst_active_out(ba), .data_invalid_out(inv), .edge_select_bit_out(es));
    flash_array_model i_arr (.clk_in(clk_in), .array_addr_in(aa), .array_data_out(ad));
    always #10 clk_in = ~clk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic check(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            $display("Error at %0t: %s", $time, m);
            bad_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic pulse;
        fclk = 1'b1;
        tick(8);
        fclk = 1'b0;
        tick(8);
    endtask
    task automatic burst(input logic [1:0] lc, input logic [3:0] lt, input bit gap, input bit wm);
        int len, lat, k, j;
        logic [20:0] m, u, v;
        logic [31:0] w;
        logic [31:0] exp_q[$];
        len = (lc == 2'h0) ? 2 : (lc == 2'h1) ? 4 : 8;
        lat = (lt > 4'hE) ? 16 : lt + 2;
        m = 21'(len - 1);
        u = wm ? {a, 1'b0} : {1'b0, a};
        for (j = 0; j <= len; j++) begin
            v = (u & ~m) | ((u + 21'(j)) & m);
            w = {12'h5A5, (wm ? v[20:1] : v[19:0])};
            exp_q.push_back(wm ? {16'h0000, (v[0] ? w[31:16] : w[15:0])} : w);
        end
        wm_n = ~wm;
        cw = 1'b1;
        cb = 1'b1;
        cl = lc;
        clat = lt;
        tick(1);
        cw = 1'b0;
        st_n = 1'b0;
        tick(6);
        check(ba === 1'b0, "burst kept after strobe fell");
        pulse;
        st_n = 1'b1;
        for (k = 1; k <= lat + len; k++) begin
            og_n = gap && k == lat + 1;
            pulse;
            j = k - lat;
            if (k >= lat) begin
                w = exp_q.pop_front();
            end
            if (og_n) begin
                check(doe === 1'b0 && eoe === 1'b0, "gate high drove pins");
            end else if (k >= lat) begin
                check(dq === w, "burst word");
                check(doe === 1'b1 && eoe === 1'b1, "pins not driven");
                check(eob === ((j % len) != (len - 1)), "end of burst");
            end
        end
    endtask
    initial begin
        tick(100000);
        bad_count++;
        report_and_stop;
    end
    initial begin
        int b;
        tick(2);
        rst_in = 1'b0;
        tick(4);
        check(bm === 1'b0 && es === 1'b1, "reset state");
        a = 20'h01234;
        cs_n = 1'b0;
        og_n = 1'b0;
        tick(8);
        check(dq === 32'h5A501234 && doe === 1'b1 && aa === a, "async read");
        og_n = 1'b1;
        tick(8);
        check(doe === 1'b0, "async drove with gate high");
        og_n = 1'b0;
        rs = 2'h1;
        a = 20'h00040;
        tick(8);
        check(inv === 1'b1 && dq === 32'h5A500040, "secured word not flagged");
        a = 20'h0003F;
        tick(8);
        check(inv === 1'b0 && dq === 32'h5A50003F, "secured word flagged");
        rs = 2'h0;
        for (b = 0; b < 5; b++) begin
            lfsr_reg = lfsr(lfsr_reg);
            a = {lfsr_reg[3:0], lfsr_reg};
            burst(2'(b), (b == 0) ? 4'h0 : (b == 3) ? 4'hF : lfsr_reg[3:0], b == 2,
                  b == 4);
        end
        cs_n = 1'b1;
        wm_n = 1'b1;
        tick(8);
        check(doe === 1'b0 && ba === 1'b0, "burst kept with select high");
        cs_n = 1'b0;
        pulse;
        pulse;
        check(ba === 1'b0, "burst restarted without strobe");
        rs = 2'h2;
        tick(8);
        check(dq === {12'h5A5, a} && doe === 1'b1, "config read");
        pulse;
        pulse;
        check(dq === {12'h5A5, a} && ba === 1'b0, "config read not held");
        rs = 2'h0;
        st_n = 1'b0;
        tick(6);
        pulse;
        rst_in = 1'b1;
        tick(2);
        check(doe === 1'b0 && ba === 1'b0 && bm === 1'b0, "reset kept burst");
        rst_in = 1'b0;
        tick(8);
        check(bm === 1'b0 && doe === 1'b1 && dq === {12'h5A5, a}, "not async after reset");
        report_and_stop;
    end
endmodule
bind flash_linear_burst_read_port burst_port_chk i_chk (.clk_in(clk_in), .rst_in(rst_in),
    .chip_select_n_in(chip_select_n_in), .output_gate_n_in(output_gate_n_in),
    .config_write_in(config_write_in), .config_burst_in(config_burst_in),
    .data_out(data_out), .data_oe_out(data_oe_out), .end_of_burst_n_out(end_of_burst_n_out),
    .end_of_burst_oe_out(end_of_burst_oe_out), .burst_mode_out(burst_mode_out),
    .burst_active_out(burst_active_out), .edge_select_bit_out(edge_select_bit_out));
